// ===== design/lah_pkg.sv
// lah_pkg: constants, register map and carrier types of the link adaptor host port.
// assumes a single 40 MHz clock shared by every user of the package.
package lah_pkg;

  // ----------------------------------------------------------------
  // clocking and link timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_BIT_NS = 100;
  // a bit time is a least time, so round up
  localparam int BIT_CYC = (LINK_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CNT_W = 8;

  // ----------------------------------------------------------------
  // packet framing
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PKT_DATA_LEN = 11;
  localparam int PKT_ACK_LEN = 2;
  localparam logic [3:0] PKT_DATA_LEN4 = 4'hb;
  localparam logic [3:0] PKT_ACK_LEN4 = 4'h2;
  localparam logic [10:0] PKT_ACK_BITS = 11'h001;

  // ----------------------------------------------------------------
  // avalon register map, index = byte address / 4
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [2:0] IDX_RX_DATA = 3'h0;
  localparam logic [2:0] IDX_TX_DATA = 3'h1;
  localparam logic [2:0] IDX_RX_STAT = 3'h2;
  localparam logic [2:0] IDX_TX_STAT = 3'h3;
  localparam logic [2:0] IDX_EVT_STAT = 3'h4;
  localparam logic [2:0] IDX_EVT_CLR = 3'h5;
  localparam logic [2:0] IDX_EVT_EN = 3'h6;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_IE_BIT = 1;
  localparam int EVT_W = 3;
  localparam int EVT_RX_BIT = 0;
  localparam int EVT_TX_BIT = 1;
  localparam int EVT_OVR_BIT = 2;
  localparam logic RST_RX_VALID = 1'b0;
  localparam logic RST_TX_READY = 1'b1;
  localparam logic RST_IE = 1'b0;
  localparam logic [2:0] RST_EVT = 3'h0;

  // ----------------------------------------------------------------
  // carrier from the link receiver
  // ----------------------------------------------------------------
  typedef struct packed {
    logic data_stb;
    logic ack_stb;
    logic [7:0] data;
  } lah_rx_evt_t;

endpackage

// ===== design/lah_link_rx.sv
// lah_link_rx: decodes data and acknowledge packets from the serial input.
// assumes serial_rx_i is already synchronous to clk_i and idles low.
`timescale 1ns/1ps
module lah_link_rx #(
  parameter int BIT_CYC = lah_pkg::BIT_CYC
) (
  input wire logic clk_i, // system clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic serial_rx_i, // serial link input
  output lah_pkg::lah_rx_evt_t evt_o // one-cycle packet strobes and byte
);

  typedef enum logic [1:0] {RX_IDLE, RX_TYPE, RX_DATA, RX_STOP} lah_rx_st_t;

  lah_rx_st_t state_ff;
  logic [lah_pkg::BIT_CNT_W-1:0] cnt_ff;
  logic [2:0] bitn_ff;
  logic [7:0] shift_ff;
  lah_pkg::lah_rx_evt_t evt_ff;

  localparam logic [lah_pkg::BIT_CNT_W-1:0] FULL_BIT = lah_pkg::BIT_CNT_W'(BIT_CYC - 1);
  // first sample lands in the middle of the type bit
  localparam logic [lah_pkg::BIT_CNT_W-1:0] FIRST_MID =
    lah_pkg::BIT_CNT_W'(BIT_CYC + BIT_CYC / 2 - 1);

  // ----------------------------------------------------------------
  // packet framing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_ff <= RX_IDLE;
      cnt_ff <= '0;
      bitn_ff <= 3'h0;
      shift_ff <= 8'h00;
      evt_ff <= '0;
    end
    else
    begin
      evt_ff.data_stb <= 1'b0;
      evt_ff.ack_stb <= 1'b0;
      if (state_ff != RX_IDLE && cnt_ff != '0)
        cnt_ff <= cnt_ff - 1'b1;
      case (state_ff)
        RX_IDLE:
        begin
          if (serial_rx_i)
          begin
            cnt_ff <= FIRST_MID;
            state_ff <= RX_TYPE;
          end
        end
        RX_TYPE:
        begin
          if (cnt_ff == '0)
          begin
            cnt_ff <= FULL_BIT;
            bitn_ff <= 3'h0;
            if (serial_rx_i)
              state_ff <= RX_DATA;
            else
            begin
              evt_ff.ack_stb <= 1'b1;
              state_ff <= RX_IDLE;
            end
          end
        end
        RX_DATA:
        begin
          if (cnt_ff == '0)
          begin
            cnt_ff <= FULL_BIT;
            shift_ff <= {serial_rx_i, shift_ff[7:1]};
            bitn_ff <= bitn_ff + 3'h1;
            if (bitn_ff == 3'h7)
              state_ff <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (cnt_ff == '0)
          begin
            // a high stop bit is a framing fault: drop the byte
            evt_ff.data_stb <= ~serial_rx_i;
            evt_ff.data <= shift_ff;
            state_ff <= RX_IDLE;
          end
        end
        default:
          state_ff <= RX_IDLE;
      endcase
    end
  end

  assign evt_o = evt_ff;

  a_strobe_single: assert property (@(posedge clk_i) disable iff (reset_i)
    evt_ff.ack_stb |=> !evt_ff.ack_stb && !evt_ff.data_stb)
    else $error("ack strobe not a single pulse");

endmodule // lah_link_rx

// ===== design/lah_host_port.sv
// lah_host_port: avalon register port, interrupts and serial transmitter of the adaptor.
// assumes an avalon-mm master on clk_i and a link partner that obeys the ack protocol.
//
// Overview of operation
// - completed data packet sets received-valid; raises receive interrupt when enabled.
// - reading receive data clears received-valid and sends an acknowledge packet.
// - a receive data read alone drops the receive interrupt.
// - empty transmit buffer keeps transmit-ready high, transmit interrupt when enabled.
// - transmit data write clears transmit-ready and starts a data packet.
// - transmit-ready stays low until the far acknowledge arrives, then rises.
// - register select and direction choose the register; two combinations are invalid.
// - clearing interrupt enable drops the interrupt; setting it again restores it.
// - writes to receive data change nothing.
// - reads of transmit data return meaningless content, here zero.
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module lah_host_port #(
  parameter int BIT_CYC = lah_pkg::BIT_CYC
) (
  input wire logic clk_i, // system clock, 40 MHz
  input wire logic reset_i, // synchronous reset, active high
  input wire logic [lah_pkg::ADDR_W-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes of a write
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall, high until the answer
  input wire logic serial_rx_i, // serial link input
  output logic serial_tx_o, // serial link output
  output logic rx_int_o, // receive buffer full interrupt
  output logic tx_int_o, // transmit buffer empty interrupt
  output logic irq_o // summary event interrupt
);

  typedef enum logic {TX_IDLE, TX_SEND} lah_tx_st_t;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  lah_pkg::lah_rx_evt_t rx_evt;
  logic waitrequest_ff;
  logic [31:0] readdata_ff;
  logic rd_saw_valid_ff;
  logic access;
  logic [2:0] idx;
  logic wr_lane0;
  logic rd_rx_data;
  logic wr_tx_data;
  logic wr_rx_stat;
  logic wr_tx_stat;
  logic rx_valid_ff;
  logic nxt_rx_valid;
  logic [7:0] rx_data_ff;
  logic rx_ie_ff;
  logic nxt_rx_ie;
  logic tx_ready_ff;
  logic nxt_tx_ready;
  logic tx_ie_ff;
  logic nxt_tx_ie;
  logic data_sent_ff;
  logic ack_got_ff;
  logic data_pend_ff;
  logic ack_pend_ff;
  logic [7:0] tx_data_ff;
  lah_tx_st_t tx_state_ff;
  logic [10:0] tx_shift_ff;
  logic [3:0] tx_bits_ff;
  logic [lah_pkg::BIT_CNT_W-1:0] tx_cnt_ff;
  logic tx_line_ff;
  logic data_done;
  logic ack_done;
  logic tx_is_data_ff;
  logic rx_int_ff;
  logic tx_int_ff;
  logic [lah_pkg::EVT_W-1:0] evt_ff;
  logic [lah_pkg::EVT_W-1:0] evt_en_ff;
  logic [lah_pkg::EVT_W-1:0] evt_set;
  logic irq_ff;

  localparam logic [lah_pkg::BIT_CNT_W-1:0] FULL_BIT = lah_pkg::BIT_CNT_W'(BIT_CYC - 1);

  function automatic logic [31:0] stat_word(input logic flag, input logic ie);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[lah_pkg::STAT_FLAG_BIT] = flag;
    w[lah_pkg::STAT_IE_BIT] = ie;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // link receiver
  // ----------------------------------------------------------------
  lah_link_rx #(
    .BIT_CYC(BIT_CYC)
  ) u_rx (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .serial_rx_i(serial_rx_i),
    .evt_o(rx_evt)
  );

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  assign idx = avs_address_i[4:2];
  assign access = (avs_read_i | avs_write_i) & ~waitrequest_ff;
  assign wr_lane0 = access & avs_write_i & avs_byteenable_i[0];
  // writes to receive data and reads of transmit data fall through here
  assign rd_rx_data = access & avs_read_i & (idx == lah_pkg::IDX_RX_DATA);
  assign wr_tx_data = wr_lane0 & (idx == lah_pkg::IDX_TX_DATA);
  assign wr_rx_stat = wr_lane0 & (idx == lah_pkg::IDX_RX_STAT);
  assign wr_tx_stat = wr_lane0 & (idx == lah_pkg::IDX_TX_STAT);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      waitrequest_ff <= 1'b1;
    else
      waitrequest_ff <= ~((avs_read_i | avs_write_i) & waitrequest_ff);
  end

  // data is captured one cycle ahead, so the valid seen is remembered too
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      readdata_ff <= 32'h0000_0000;
      rd_saw_valid_ff <= 1'b0;
    end
    else if (avs_read_i & waitrequest_ff)
    begin
      rd_saw_valid_ff <= rx_valid_ff;
      case (idx)
        lah_pkg::IDX_RX_DATA: readdata_ff <= {24'h000000, rx_data_ff};
        lah_pkg::IDX_TX_DATA: readdata_ff <= 32'h0000_0000;
        lah_pkg::IDX_RX_STAT: readdata_ff <= stat_word(rx_valid_ff, rx_ie_ff);
        lah_pkg::IDX_TX_STAT: readdata_ff <= stat_word(tx_ready_ff, tx_ie_ff);
        lah_pkg::IDX_EVT_STAT: readdata_ff <= {29'h0, evt_ff};
        lah_pkg::IDX_EVT_EN: readdata_ff <= {29'h0, evt_en_ff};
        default: readdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive side flags
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_rx_valid = rx_valid_ff;
    if (rd_rx_data & rd_saw_valid_ff)
      nxt_rx_valid = 1'b0;
    if (rx_evt.data_stb)
      nxt_rx_valid = 1'b1;
    nxt_rx_ie = wr_rx_stat ? avs_writedata_i[lah_pkg::STAT_IE_BIT] : rx_ie_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_valid_ff <= lah_pkg::RST_RX_VALID;
      rx_ie_ff <= lah_pkg::RST_IE;
      rx_data_ff <= 8'h00;
    end
    else
    begin
      rx_valid_ff <= nxt_rx_valid;
      rx_ie_ff <= nxt_rx_ie;
      if (rx_evt.data_stb)
        rx_data_ff <= rx_evt.data;
    end
  end

  a_rx_sets_valid: assert property (@(posedge clk_i) disable iff (reset_i)
    rx_evt.data_stb |=> rx_valid_ff ##0 (rx_int_o == rx_ie_ff))
    else $error("received packet did not set valid");

  a_rd_clears_int: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_rx_data && rd_saw_valid_ff && !rx_evt.data_stb |=> !rx_int_o && !rx_valid_ff)
    else $error("receive data read left interrupt high");

  a_rxwr_no_effect: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_lane0 && idx == lah_pkg::IDX_RX_DATA && !rx_evt.data_stb |=> $stable(rx_valid_ff))
    else $error("write to receive data changed state");

  // ----------------------------------------------------------------
  // transmit side flags
  // ----------------------------------------------------------------
  assign data_done = tx_state_ff == TX_SEND && tx_is_data_ff && tx_bits_ff == 4'h1 &&
    tx_cnt_ff == '0;
  assign ack_done = tx_state_ff == TX_SEND && !tx_is_data_ff && tx_bits_ff == 4'h1 &&
    tx_cnt_ff == '0;

  always_comb
  begin
    nxt_tx_ready = tx_ready_ff;
    // both the packet and the far acknowledge must be complete
    if (!tx_ready_ff && (data_sent_ff | data_done) && (ack_got_ff | rx_evt.ack_stb))
      nxt_tx_ready = 1'b1;
    if (wr_tx_data)
      nxt_tx_ready = 1'b0;
    nxt_tx_ie = wr_tx_stat ? avs_writedata_i[lah_pkg::STAT_IE_BIT] : tx_ie_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_ready_ff <= lah_pkg::RST_TX_READY;
      tx_ie_ff <= lah_pkg::RST_IE;
      data_sent_ff <= 1'b0;
      ack_got_ff <= 1'b0;
    end
    else
    begin
      tx_ready_ff <= nxt_tx_ready;
      tx_ie_ff <= nxt_tx_ie;
      if (wr_tx_data)
      begin
        data_sent_ff <= 1'b0;
        ack_got_ff <= 1'b0;
      end
      else
      begin
        if (data_done)
          data_sent_ff <= 1'b1;
        if (rx_evt.ack_stb && !tx_ready_ff)
          ack_got_ff <= 1'b1;
      end
    end
  end

  a_rdy_waits_ack: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(tx_ready_ff) |-> $past(ack_got_ff) || $past(rx_evt.ack_stb))
    else $error("transmit ready rose without acknowledge");

  // ----------------------------------------------------------------
  // transmitter: acknowledges go ahead of pending data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ack_pend_ff <= 1'b0;
      data_pend_ff <= 1'b0;
      tx_data_ff <= 8'h00;
    end
    else
    begin
      // an empty buffer read owes no acknowledge
      if (rd_rx_data && rd_saw_valid_ff)
        ack_pend_ff <= 1'b1;
      else if (tx_state_ff == TX_IDLE)
        ack_pend_ff <= 1'b0;
      if (wr_tx_data)
      begin
        data_pend_ff <= 1'b1;
        tx_data_ff <= avs_writedata_i[7:0];
      end
      else if (tx_state_ff == TX_IDLE && !ack_pend_ff)
        data_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_state_ff <= TX_IDLE;
      tx_shift_ff <= 11'h000;
      tx_bits_ff <= 4'h0;
      tx_cnt_ff <= '0;
      tx_line_ff <= 1'b0;
      tx_is_data_ff <= 1'b0;
    end
    else
    begin
      case (tx_state_ff)
        TX_IDLE:
        begin
          tx_line_ff <= 1'b0;
          tx_cnt_ff <= FULL_BIT;
          if (ack_pend_ff)
          begin
            tx_shift_ff <= lah_pkg::PKT_ACK_BITS;
            tx_bits_ff <= lah_pkg::PKT_ACK_LEN4;
            tx_is_data_ff <= 1'b0;
            tx_state_ff <= TX_SEND;
          end
          else if (data_pend_ff)
          begin
            tx_shift_ff <= {1'b0, tx_data_ff, 2'b11};
            tx_bits_ff <= lah_pkg::PKT_DATA_LEN4;
            tx_is_data_ff <= 1'b1;
            tx_state_ff <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          tx_line_ff <= tx_shift_ff[0];
          if (tx_cnt_ff != '0)
            tx_cnt_ff <= tx_cnt_ff - 1'b1;
          else
          begin
            tx_cnt_ff <= FULL_BIT;
            tx_shift_ff <= {1'b0, tx_shift_ff[10:1]};
            tx_bits_ff <= tx_bits_ff - 4'h1;
            if (tx_bits_ff == 4'h1)
              tx_state_ff <= TX_IDLE;
          end
        end
        default:
          tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  a_rd_sends_ack: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_rx_data && rd_saw_valid_ff |-> ##[1:60] (tx_state_ff == TX_SEND && !tx_is_data_ff))
    else $error("no acknowledge after receive data read");

  a_no_ack_empty: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_rx_data && !rd_saw_valid_ff && !ack_pend_ff |=> !ack_pend_ff)
    else $error("acknowledge queued for an empty read");

  a_wr_starts_tx: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_tx_data |=> !tx_ready_ff ##[1:80] (tx_state_ff == TX_SEND && tx_is_data_ff))
    else $error("transmit write did not start a packet");

  // ----------------------------------------------------------------
  // interrupts and sticky events
  // ----------------------------------------------------------------
  assign evt_set[lah_pkg::EVT_RX_BIT] = rx_evt.data_stb;
  assign evt_set[lah_pkg::EVT_TX_BIT] = nxt_tx_ready & ~tx_ready_ff;
  // a packet landing on unread data overwrites it
  assign evt_set[lah_pkg::EVT_OVR_BIT] = rx_evt.data_stb & rx_valid_ff;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_int_ff <= 1'b0;
      tx_int_ff <= 1'b0;
      irq_ff <= 1'b0;
      evt_ff <= lah_pkg::RST_EVT;
      evt_en_ff <= lah_pkg::RST_EVT;
    end
    else
    begin
      rx_int_ff <= nxt_rx_valid & nxt_rx_ie;
      tx_int_ff <= nxt_tx_ready & nxt_tx_ie;
      // set wins over a clear in the same cycle
      if (wr_lane0 && idx == lah_pkg::IDX_EVT_CLR)
        evt_ff <= (evt_ff & ~avs_writedata_i[lah_pkg::EVT_W-1:0]) | evt_set;
      else
        evt_ff <= evt_ff | evt_set;
      if (wr_lane0 && idx == lah_pkg::IDX_EVT_EN)
        evt_en_ff <= avs_writedata_i[lah_pkg::EVT_W-1:0];
      irq_ff <= |(evt_ff & evt_en_ff);
    end
  end

  a_tx_int_level: assert property (@(posedge clk_i) disable iff (reset_i)
    tx_ready_ff && tx_ie_ff |-> tx_int_o)
    else $error("transmit interrupt low while ready and enabled");

  a_ie_gates_int: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_rx_stat && !avs_writedata_i[lah_pkg::STAT_IE_BIT] |=> !rx_int_o [*2])
    else $error("receive interrupt high with enable cleared");

  a_reset_state: assert property (@(posedge clk_i)
    reset_i |=> tx_ready_ff && !rx_valid_ff && !rx_int_o && !tx_int_o && !irq_o)
    else $error("reset state wrong");

  assign avs_readdata_o = readdata_ff;
  assign avs_waitrequest_o = waitrequest_ff;
  assign serial_tx_o = tx_line_ff;
  assign rx_int_o = rx_int_ff;
  assign tx_int_o = tx_int_ff;
  assign irq_o = irq_ff;

endmodule // lah_host_port

// ===== verification/lah_link_peer.sv
// lah_link_peer: behavioural far end of the serial link.
// assumes bc_p clk_i cycles per bit and both lines idling low.
`timescale 1ns/1ps
module lah_link_peer #(
  parameter int bc_p = 2
) (
  input wire logic clk_i, // system clock
  input wire logic tx_i, // line from the adaptor
  output logic rx_o // line into the adaptor
);
  logic [10:0] q[$];
  int len_q[$];
  logic [7:0] got_q[$];
  logic [7:0] b;
  int n_ack = 0;
  int n_sent = 0;
  int ack_dly = 0;

  initial rx_o = 1'b0;

  task automatic send(input logic [10:0] bits, input int len);
    q.push_back(bits);
    len_q.push_back(len);
  endtask

  // ----------------------------------------
  // sender, one packet at a time
  // ----------------------------------------
  always
  begin
    wait (q.size() != 0);
    @(posedge clk_i);
    // counted at its start, so a ready flag seen later must follow it
    if (len_q[0] == 2)
      n_sent++;
    for (int i = 0; i < len_q[0]; i++)
      repeat (bc_p) @(posedge clk_i) rx_o <= q[0][i];
    q.pop_front();
    len_q.pop_front();
    repeat (bc_p) @(posedge clk_i) rx_o <= 1'b0;
  end

  // ----------------------------------------
  // receiver, answers every data packet
  // ----------------------------------------
  always
  begin
    @(posedge clk_i);
    if (tx_i === 1'b1)
    begin
      repeat (bc_p) @(posedge clk_i);
      if (tx_i === 1'b0)
        n_ack++;
      else
      begin
        for (int i = 0; i < 8; i++)
          repeat (bc_p) @(posedge clk_i) b[i] = tx_i;
        repeat (bc_p) @(posedge clk_i);
        got_q.push_back(b);
        fork
          begin
            repeat (ack_dly) @(posedge clk_i);
            send(11'h001, 2);
          end
        join_none
      end
    end
  end
endmodule // lah_link_peer

// ===== verification/lah_host_port_test.sv
// lah_host_port_test: self-checking bench of the adaptor host port.
// assumes lah_link_peer stands on the serial link.
`timescale 1ns/1ps
module lah_host_port_test;
  localparam int bc = 2; // short bit time keeps the run brief
  logic clk_i;
  logic reset_i;
  logic [4:0] adr;
  logic rd_q;
  logic wr_q;
  logic [31:0] wd;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wreq;
  logic tx_line;
  logic rx_line;
  logic rx_int;
  logic tx_int;
  logic irq;
  logic [31:0] r;
  logic [7:0] d;
  int n_fail = 0;
  int tests_run = 0;
  int s;
  bit rx_v = 0;
  bit tx_r = 1;
  bit rx_ie = 0;
  bit tx_ie = 0;
  bit [2:0] evt = 0;
  bit [2:0] en = 0;

  lah_host_port #(.BIT_CYC(bc)) u_dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .avs_address_i(adr),
    .avs_read_i(rd_q),
    .avs_write_i(wr_q),
    .avs_writedata_i(wd),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq),
    .serial_rx_i(rx_line),
    .serial_tx_o(tx_line),
    .rx_int_o(rx_int),
    .tx_int_o(tx_int),
    .irq_o(irq)
  );

  lah_link_peer #(.bc_p(bc)) u_peer (
    .clk_i(clk_i),
    .tx_i(tx_line),
    .rx_o(rx_line)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic results;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cut;
    n_fail++;
    results();
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] v);
    int n;
    n = 0;
    adr <= a;
    rd_q <= ~w;
    wr_q <= w;
    wd <= v;
    be <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    r = rdata;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    // one idle edge so no request signal is driven twice in a time step
    @(posedge clk_i);
    if (n >= 20)
      cut();
  endtask

  task automatic rd(input logic [4:0] a, input string nm, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    cmp(nm, e, r);
  endtask

  task automatic poll(input logic [4:0] a);
    int n;
    n = 0;
    do
    begin
      bus(a, 1'b0, 32'h0);
      n++;
    end
    while (r[0] !== 1'b1 && n < 100);
    if (r[0] !== 1'b1)
      cut();
  endtask

  task automatic wait_rx;
    int n;
    n = 0;
    while (rx_int !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400)
      cut();
  endtask

  // interrupt pins are registered, so let two edges land first
  task automatic pins;
    repeat (2) @(posedge clk_i);
    cmp_bit("rx_int", rx_v & rx_ie, rx_int);
    cmp_bit("tx_int", tx_r & tx_ie, tx_int);
    cmp_bit("irq", |(evt & en), irq);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    reset_i = 1'b1;
    adr = 5'h00;
    rd_q = 1'b0;
    wr_q = 1'b0;
    wd = 32'h0;
    be = 4'hf;
    s = $urandom(32'h0728c3de);
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(5'h08, "rx_stat", 32'h0);
    rd(5'h0c, "tx_stat", 32'h1);
    rd(5'h1c, "unmapped", 32'h0);
    pins();
    for (int k = 0; k < 4; k++)
    begin
      rx_ie = k[0];
      bus(5'h08, 1'b1, {30'h0, rx_ie, 1'b0});
      d = 8'($urandom);
      u_peer.send({1'b0, d, 2'b11}, 11);
      if (rx_ie)
        wait_rx();
      else
        poll(5'h08);
      rx_v = 1;
      evt[0] = 1'b1;
      rd(5'h08, "rx_stat", {30'h0, rx_ie, rx_v});
      pins();
      if (rx_ie)
      begin
        rx_ie = 0;
        bus(5'h08, 1'b1, 32'h0);
        pins();
        rx_ie = 1;
        bus(5'h08, 1'b1, 32'h2);
        pins();
      end
      bus(5'h00, 1'b1, {24'h0, ~d});
      rd(5'h00, "rx_data", {24'h0, d});
      rx_v = 0;
      pins();
      rd(5'h08, "rx_stat", {30'h0, rx_ie, rx_v});
      repeat (12 * bc) @(posedge clk_i);
      cmp("acks", k + 1, u_peer.n_ack);
    end
    bus(5'h00, 1'b0, 32'h0);
    repeat (12 * bc) @(posedge clk_i);
    cmp("acks", 4, u_peer.n_ack);
    for (int k = 0; k < 4; k++)
    begin
      tx_ie = k[0];
      u_peer.ack_dly = k[1] ? 60 : 0;
      bus(5'h0c, 1'b1, {30'h0, tx_ie, 1'b0});
      poll(5'h0c);
      pins();
      d = 8'($urandom);
      s = u_peer.n_sent;
      bus(5'h04, 1'b1, {24'h0, d});
      tx_r = 0;
      rd(5'h0c, "tx_stat", {30'h0, tx_ie, tx_r});
      pins();
      rd(5'h04, "tx_data", 32'h0);
      poll(5'h0c);
      cmp("acks_sent", 1, u_peer.n_sent - s);
      tx_r = 1;
      evt[1] = 1'b1;
      pins();
      cmp("tx_byte", {24'h0, d}, {24'h0, u_peer.got_q.pop_front()});
    end
    // two packets with no read between: the second overwrites the first
    d = 8'($urandom);
    u_peer.send({1'b0, ~d, 2'b11}, 11);
    u_peer.send({1'b0, d, 2'b11}, 11);
    repeat (40 * bc) @(posedge clk_i);
    evt[2] = 1'b1;
    rx_v = 1;
    pins();
    rd(5'h00, "rx_ovr", {24'h0, d});
    rx_v = 0;
    rd(5'h10, "evt", {29'h0, evt});
    en = 3'h3;
    bus(5'h18, 1'b1, 32'h3);
    pins();
    rd(5'h18, "evt_en", 32'h3);
    evt = 3'h0;
    bus(5'h14, 1'b1, 32'h7);
    pins();
    rd(5'h10, "evt", 32'h0);
    results();
  end
endmodule // lah_host_port_test
